// [core/rxbe_pkg.sv]
// Constants, register map and field layout of the receive path back end
package rxbe_pkg;
  localparam logic [7:0] ADDR_TAP = 8'h05;
  localparam logic [7:0] ADDR_JA_CFG = 8'h27;
  localparam logic [7:0] ADDR_CFG0 = 8'h28;
  localparam logic [7:0] ADDR_CFG1 = 8'h29;
  localparam logic [7:0] ADDR_CFG2 = 8'h2a;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h34;
  localparam logic [7:0] ADDR_LINE_STAT = 8'h37;
  localparam logic [7:0] ADDR_GAP = 8'h39;
  localparam logic [7:0] ADDR_EVENTS = 8'h3b;
  // rx_ja_config fields
  localparam int JA_EN_BIT = 0;
  localparam int JA_DP_LSB = 1;
  localparam int JA_BW_BIT = 3;
  localparam int JA_GUARD_BIT = 4;
  localparam int JA_PEAK_BIT = 5;
  // rx_config_0 fields
  localparam int CFG0_MD_LSB = 0;
  localparam int CFG0_EDGE_BIT = 2;
  localparam int CFG0_INV_BIT = 3;
  localparam int CFG0_OFF_BIT = 4;
  localparam int CFG0_E1_BIT = 5;
  localparam int CFG0_RLB_BIT = 6;
  // rx_config_1 / rx_config_2 fields
  localparam int CFG1_EQ_BIT = 0;
  localparam int CFG2_SLICE_LSB = 0;
  localparam int CFG2_WIN_LSB = 2;
  localparam int CFG2_GAIN_LSB = 4;
  localparam int SLIP_BIT = 0;
  localparam logic [7:0] CFG2_RESET = 8'h08;
  localparam logic [7:0] JA_CFG_RESET = 8'h02;
  localparam logic [1:0] MD_BYPASS = 2'h3;
  // Coding modes in rx_coding_mode
  localparam logic [1:0] MD_SR_SUB = 2'h0;
  localparam logic [1:0] MD_SR_AMI = 2'h1;
  localparam logic [1:0] MD_DR = 2'h2;
  // Tap field: 0 off, 1..7 receive of channel n+1, 9..15 transmit of channel n-7
  localparam logic [3:0] TAP_OFF = 4'h0;
  localparam int TAP_TX_BIT = 3;
  localparam logic [6:0] GAP_W = 7'h7f;
  localparam int EQ_STEPS = 32;
endpackage

// [core/rxbe_top.sv]
// Receive path back end: slicer, recovery, decoder, jitter attenuator, registers
`timescale 1ns/1ps
`default_nettype none
module rxbe_top #(
  parameter int CHANNELS = 8,
  parameter int OVERSAMPLE_DIV = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [6:0] slice_pos,
  input wire logic [6:0] slice_neg,
  input wire logic [6:0] line_peak,
  input wire logic line_clk_in,
  input wire logic [CHANNELS-1:0] tap_rx_pos,
  input wire logic [CHANNELS-1:0] tap_rx_neg,
  input wire logic [CHANNELS-1:0] tap_tx_pos,
  input wire logic [CHANNELS-1:0] tap_tx_neg,
  input wire logic signal_loss_in,
  output logic rx_recovered_clock,
  output logic rx_data_pos,
  output logic rx_data_neg,
  output logic signal_loss_out,
  output logic line_tx_pos,
  output logic line_tx_neg,
  output logic [1:0] boost_gain_select,
  output logic [1:0] decision_threshold_select,
  output logic [4:0] eq_setting,
  output logic irq_n
);
  import rxbe_pkg::*;
  localparam int FW = 7;

  logic [7:0] tap_r, ja_cfg_r, cfg0_r, cfg1_r, cfg2_r, irq_en_r;
  logic slip_r;
  logic [4:0] cable_loss_level_r;
  logic [6:0] pointer_gap_value_r;

  wire logic [1:0] rx_coding_mode = cfg0_r[CFG0_MD_LSB +: 2];
  wire logic rx_ja_enable = ja_cfg_r[JA_EN_BIT];
  wire logic [1:0] rx_ja_depth = ja_cfg_r[JA_DP_LSB +: 2];
  wire logic rx_ja_corner = ja_cfg_r[JA_BW_BIT];
  wire logic rx_ja_guard_enable = ja_cfg_r[JA_GUARD_BIT];
  wire logic peak_hold_select = ja_cfg_r[JA_PEAK_BIT];
  wire logic rx_data_polarity = cfg0_r[CFG0_INV_BIT];
  wire logic power_down = cfg0_r[CFG0_OFF_BIT];
  wire logic e1_mode = cfg0_r[CFG0_E1_BIT];
  wire logic equalizer_enable = cfg1_r[CFG1_EQ_BIT];
  wire logic [3:0] tap_source_select = tap_r[3:0];
  logic slip_set;

  // Register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_r <= 8'h00;
      ja_cfg_r <= JA_CFG_RESET;
      cfg0_r <= 8'h00;
      cfg1_r <= 8'h00;
      cfg2_r <= CFG2_RESET;
      irq_en_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_TAP) begin
        tap_r <= reg_wdata;
      end else if (reg_addr == ADDR_JA_CFG) begin
        ja_cfg_r <= reg_wdata;
      end else if (reg_addr == ADDR_CFG0) begin
        cfg0_r <= reg_wdata;
      end else if (reg_addr == ADDR_CFG1) begin
        cfg1_r <= reg_wdata;
      end else if (reg_addr == ADDR_CFG2) begin
        cfg2_r <= reg_wdata;
      end else if (reg_addr == ADDR_IRQ_EN) begin
        irq_en_r <= reg_wdata;
      end
    end
  end

  // sticky slip, set wins over write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slip_r <= 1'b0;
    end else if (slip_set) begin
      slip_r <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_EVENTS && reg_wdata[SLIP_BIT]) begin
      slip_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(slip_r & irq_en_r[SLIP_BIT]);
    end
  end

  // Register reads, data one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_TAP) begin
        reg_rdata <= tap_r;
      end else if (reg_addr == ADDR_JA_CFG) begin
        reg_rdata <= ja_cfg_r;
      end else if (reg_addr == ADDR_CFG0) begin
        reg_rdata <= cfg0_r;
      end else if (reg_addr == ADDR_CFG1) begin
        reg_rdata <= cfg1_r;
      end else if (reg_addr == ADDR_CFG2) begin
        reg_rdata <= cfg2_r;
      end else if (reg_addr == ADDR_IRQ_EN) begin
        reg_rdata <= irq_en_r;
      end else if (reg_addr == ADDR_LINE_STAT) begin
        reg_rdata <= {3'h0, cable_loss_level_r};
      end else if (reg_addr == ADDR_GAP) begin
        reg_rdata <= {1'b0, pointer_gap_value_r};
      end else if (reg_addr == ADDR_EVENTS) begin
        reg_rdata <= {7'h00, slip_r};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // boost gain; slicer threshold go to the analog front end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_gain_select <= 2'h0;
      decision_threshold_select <= 2'h0;
    end else begin
      boost_gain_select <= cfg2_r[CFG2_GAIN_LSB +: 2];
      decision_threshold_select <= cfg2_r[CFG2_SLICE_LSB +: 2];
    end
  end

  // Synchronise pins and the line clock (sample inputs)
  logic [1:0] s1_r, s2_r;
  logic s3_r;
  logic [6:0] pos_m_r, neg_m_r, pk_m_r, pk_s_r;
  logic [CHANNELS-1:0] trp_m_r, trn_m_r, ttp_m_r, ttn_m_r;
  logic [CHANNELS-1:0] trp_r, trn_r, ttp_r, ttn_r;
  logic [6:0] pos_s_r, neg_s_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 1'b0;
      pk_m_r <= 7'h00;
      pk_s_r <= 7'h00;
      pos_m_r <= 7'h00;
      neg_m_r <= 7'h00;
      pos_s_r <= 7'h00;
      neg_s_r <= 7'h00;
      trp_m_r <= '0;
      trn_m_r <= '0;
      ttp_m_r <= '0;
      ttn_m_r <= '0;
      trp_r <= '0;
      trn_r <= '0;
      ttp_r <= '0;
      ttn_r <= '0;
    end else begin
      s1_r <= {signal_loss_in, line_clk_in};
      s2_r <= s1_r;
      s3_r <= s2_r[0];
      pk_m_r <= line_peak;
      pk_s_r <= pk_m_r;
      pos_m_r <= slice_pos;
      neg_m_r <= slice_neg;
      pos_s_r <= pos_m_r;
      neg_s_r <= neg_m_r;
      trp_m_r <= tap_rx_pos;
      trn_m_r <= tap_rx_neg;
      ttp_m_r <= tap_tx_pos;
      ttn_m_r <= tap_tx_neg;
      trp_r <= trp_m_r;
      trn_r <= trn_m_r;
      ttp_r <= ttp_m_r;
      ttn_r <= ttn_m_r;
    end
  end
  wire logic sym_tick = s2_r[0] & ~s3_r;
  wire logic loss_s = s2_r[1];

  // Slicer: sample levels against threshold of peak
  function automatic logic above(input logic [6:0] lvl, input logic [6:0] pk,
                                 input logic [1:0] sel);
    logic [10:0] thr;
    thr = 11'(pk) * 11'(4 + sel);
    above = (11'(lvl) * 11'd10) > thr;
  endfunction

  // channel 1 may take another channel's line
  logic tap_on;
  logic [2:0] tap_ch;
  logic in_pos, in_neg;
  always_comb begin
    tap_on = tap_source_select != TAP_OFF;
    tap_ch = tap_source_select[2:0];
    in_pos = above(pos_s_r, pk_s_r, decision_threshold_select);
    in_neg = above(neg_s_r, pk_s_r, decision_threshold_select);
    if (tap_on && tap_source_select[TAP_TX_BIT]) begin
      in_pos = ttp_r[tap_ch];
      in_neg = ttn_r[tap_ch];
    end else if (tap_on) begin
      in_pos = trp_r[tap_ch];
      in_neg = trn_r[tap_ch];
    end
  end

  // window count, peak tracking, equalizer update
  logic [8:0] win_cnt_r;
  logic [6:0] win_peak_r;
  wire logic [8:0] win_len = 9'(32) << cfg2_r[CFG2_WIN_LSB +: 2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_r <= 9'h000;
      win_peak_r <= 7'h00;
      cable_loss_level_r <= 5'h00;
      eq_setting <= 5'h00;
    end else if (!equalizer_enable) begin
      win_cnt_r <= 9'h000;
      win_peak_r <= 7'h00;
    end else if (sym_tick) begin
      if (win_cnt_r == win_len - 9'h001) begin
        win_cnt_r <= 9'h000;
        win_peak_r <= 7'h00;
        cable_loss_level_r <= 5'(EQ_STEPS - 1) - win_peak_r[6:2];
        eq_setting <= 5'(EQ_STEPS - 1) - win_peak_r[6:2];
      end else begin
        win_cnt_r <= win_cnt_r + 9'h001;
        if (pk_s_r > win_peak_r) begin
          win_peak_r <= pk_s_r;
        end
      end
    end
  end

  // symbol period learnt from the line clock, kept while it is absent
  logic [7:0] sym_cnt_r, sym_per_r;
  logic rec_tick, rec_pos, rec_neg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_cnt_r <= 8'h00;
      sym_per_r <= 8'(OVERSAMPLE_DIV);
      rec_tick <= 1'b0;
      rec_pos <= 1'b0;
      rec_neg <= 1'b0;
    end else begin
      rec_tick <= 1'b0;
      if (sym_cnt_r != 8'hff) begin
        sym_cnt_r <= sym_cnt_r + 8'h01;
      end
      if (sym_tick) begin
        sym_cnt_r <= 8'h00;
        rec_tick <= 1'b1;
        rec_pos <= in_pos;
        rec_neg <= in_neg;
        // A gap longer than the counter is an outage, not a period
        if (sym_cnt_r != 8'hff) begin
          sym_per_r <= sym_cnt_r + 8'h01;
        end
      end
    end
  end

  // AMI/B8ZS/HDB3 decoder with code error flag
  logic [3:0] hist_p_r, hist_n_r;
  logic last_pol_r;
  logic dec_data, dec_err;
  always_comb begin
    dec_data = rec_pos | rec_neg;
    dec_err = (rec_pos & rec_neg) |
              (rec_pos & last_pol_r) | (rec_neg & ~last_pol_r);
    if (rx_coding_mode == MD_SR_SUB && e1_mode && dec_err &&
        hist_p_r[2:0] == 3'h0 && hist_n_r[2:0] == 3'h0) begin
      dec_data = 1'b0;
      dec_err = 1'b0;
    end else if (rx_coding_mode == MD_SR_SUB && !e1_mode && dec_err &&
                 (hist_p_r[3] | hist_n_r[3])) begin
      dec_data = 1'b0;
      dec_err = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_p_r <= 4'h0;
      hist_n_r <= 4'h0;
      last_pol_r <= 1'b0;
    end else if (rec_tick) begin
      hist_p_r <= {hist_p_r[2:0], rec_pos};
      hist_n_r <= {hist_n_r[2:0], rec_neg};
      if (rec_pos ^ rec_neg) begin
        last_pol_r <= rec_pos;
      end
    end
  end

  logic [127:0] fifo_r;
  logic [FW-1:0] wp_r, rp_r;
  logic [1:0] depth_prev_r;
  logic en_prev_r;
  logic [15:0] dpll_cnt_r;
  logic [7:0] rd_per_r, rd_cnt_r;
  wire logic [7:0] depth = 8'(32) << rx_ja_depth;
  wire logic [FW-1:0] gap = (wp_r - rp_r) & FW'(depth - 8'h01);
  wire logic [FW-1:0] half = FW'(depth >> 1);
  wire logic [FW-1:0] guard = FW'(2) + FW'(rx_ja_depth);
  wire logic [15:0] dpll_len = rx_ja_corner ? (e1_mode ? 16'h1f00 : 16'h1500)
                                            : (e1_mode ? 16'h0400 : 16'h0540);
  wire logic rd_base = rd_cnt_r >= rd_per_r - 8'h01;
  logic rd_tick;
  always_comb begin
    rd_tick = rd_base;
    // guard band speeds or slows the read side
    if (rx_ja_guard_enable && gap >= FW'(depth) - guard) begin
      rd_tick = rd_base | rec_tick;
    end else if (rx_ja_guard_enable && gap <= guard) begin
      rd_tick = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_r <= '0;
      wp_r <= '0;
      rp_r <= '0;
      depth_prev_r <= 2'h0;
      en_prev_r <= 1'b0;
      slip_set <= 1'b0;
      dpll_cnt_r <= 16'h0000;
      rd_per_r <= 8'(OVERSAMPLE_DIV);
      rd_cnt_r <= 8'h00;
    end else begin
      depth_prev_r <= rx_ja_depth;
      en_prev_r <= rx_ja_enable;
      slip_set <= 1'b0;
      dpll_cnt_r <= (dpll_cnt_r == dpll_len) ? 16'h0000 : dpll_cnt_r + 16'h0001;
      // read side takes the learnt period at the corner rate
      if (!rx_ja_enable || dpll_cnt_r == dpll_len) begin
        rd_per_r <= sym_per_r;
      end
      rd_cnt_r <= rd_base ? 8'h00 : rd_cnt_r + 8'h01;
      if (rx_ja_enable && (!en_prev_r || depth_prev_r != rx_ja_depth)) begin
        wp_r <= half;
        rp_r <= '0;
      end else if (rx_ja_enable) begin
        if (rec_tick) begin
          fifo_r[wp_r] <= dec_data;
          wp_r <= (wp_r + FW'(1)) & FW'(depth - 8'h01);
        end
        if (rd_tick) begin
          rp_r <= (rp_r + FW'(1)) & FW'(depth - 8'h01);
        end
        if ((gap & FW'(depth - 8'h01)) == '0 && (rec_tick | rd_tick)) begin
          slip_set <= 1'b1;
          wp_r <= half;
          rp_r <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_gap_value_r <= 7'h00;
    end else if (!peak_hold_select) begin
      pointer_gap_value_r <= gap & GAP_W;
    end else if (gap > pointer_gap_value_r) begin
      pointer_gap_value_r <= gap;
    end
  end

  logic out_tick, clk_lvl_r;
  logic [7:0] half_cnt_r;
  always_comb begin
    out_tick = rx_ja_enable ? rd_tick : rec_tick;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_recovered_clock <= 1'b0;
      rx_data_pos <= 1'b0;
      rx_data_neg <= 1'b0;
      signal_loss_out <= 1'b0;
      clk_lvl_r <= 1'b0;
      half_cnt_r <= 8'h00;
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
    end else if (power_down) begin
      rx_recovered_clock <= 1'b0;
      rx_data_pos <= 1'b0;
      rx_data_neg <= 1'b0;
      signal_loss_out <= 1'b0;
    end else begin
      signal_loss_out <= loss_s;
      // loopback of tapped data to line
      line_tx_pos <= cfg0_r[CFG0_RLB_BIT] & tap_on & in_pos;
      line_tx_neg <= cfg0_r[CFG0_RLB_BIT] & tap_on & in_neg;
      if (rx_coding_mode == MD_BYPASS) begin
        // bypass, clock is XOR of rails
        rx_data_pos <= in_pos ^ rx_data_polarity;
        rx_data_neg <= in_neg ^ rx_data_polarity;
        rx_recovered_clock <= in_pos ^ in_neg;
      end else begin
        // Clock rises (falls with the edge bit set) with each output symbol and turns back half a period later
        if (out_tick) begin
          half_cnt_r <= 8'h00;
          clk_lvl_r <= 1'b1;
        end else begin
          half_cnt_r <= half_cnt_r + 8'h01;
          if (half_cnt_r == (sym_per_r >> 1)) begin
            clk_lvl_r <= 1'b0;
          end
        end
        rx_recovered_clock <= clk_lvl_r ^ cfg0_r[CFG0_EDGE_BIT];
        if (out_tick) begin
          if (rx_coding_mode == MD_DR) begin
            rx_data_pos <= rec_pos ^ rx_data_polarity;
            rx_data_neg <= rec_neg ^ rx_data_polarity;
          end else begin
            rx_data_pos <= (rx_ja_enable ? fifo_r[rp_r] : dec_data) ^ rx_data_polarity;
            rx_data_neg <= dec_err;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/rxbe_top_assertions.sv]
// Port checker of the receive path back end
`timescale 1ns/1ps
`default_nettype none
module rxbe_checker
  import rxbe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic signal_loss_in,
  input wire logic rx_recovered_clock,
  input wire logic rx_data_pos,
  input wire logic rx_data_neg,
  input wire logic signal_loss_out,
  input wire logic line_tx_pos,
  input wire logic line_tx_neg,
  input wire logic [1:0] boost_gain_select,
  input wire logic [1:0] decision_threshold_select,
  input wire logic [4:0] eq_setting,
  input wire logic irq_n
);
  logic [7:0] cfg0_s;
  logic [7:0] cfg2_s;
  logic eq_s;
  logic ie_s;
  logic [2:0] settle;
  logic quiet;
  logic off;
  // Shadow copies of the written configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg0_s <= 8'h00;
      cfg2_s <= CFG2_RESET;
      eq_s <= 1'b0;
      ie_s <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CFG0) cfg0_s <= reg_wdata;
      if (reg_addr == ADDR_CFG2) cfg2_s <= reg_wdata;
      if (reg_addr == ADDR_CFG1) eq_s <= reg_wdata[CFG1_EQ_BIT];
      if (reg_addr == ADDR_IRQ_EN) ie_s <= reg_wdata[SLIP_BIT];
    end
  end
  // Gives the outputs time to follow a new setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) settle <= 3'h0;
    else if (reg_wr) settle <= 3'h7;
    else if (settle != 3'h0) settle <= settle - 3'h1;
  end
  assign quiet = (settle == 3'h0);
  assign off = cfg0_s[CFG0_OFF_BIT];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_gain_copy: assert property (quiet |-> boost_gain_select == cfg2_s[5:4])
    else $error("boost gain differs from its field");
  a_slice_copy: assert property (quiet |-> decision_threshold_select == cfg2_s[1:0])
    else $error("threshold select differs from its field");
  a_power_quiet: assert property (quiet && off |-> !(rx_recovered_clock || rx_data_pos ||
    rx_data_neg || signal_loss_out)) else $error("outputs active in power down");
  a_loss_follow: assert property (quiet && !off && $past(rst_n, 3) |->
    signal_loss_out == $past(signal_loss_in, 3)) else $error("loss output lags its input");
  a_bypass_xor: assert property (quiet && !off && cfg0_s[1:0] == MD_BYPASS |->
    rx_recovered_clock == (rx_data_pos ^ rx_data_neg)) else $error("bypass clock not xor");
  a_tx_quiet: assert property (quiet && !cfg0_s[CFG0_RLB_BIT] |-> !line_tx_pos && !line_tx_neg)
    else $error("line transmit active without loopback");
  a_eq_hold: assert property (quiet && !eq_s |=> $stable(eq_setting))
    else $error("equalizer moved while disabled");
  a_irq_masked: assert property (quiet && !ie_s |-> irq_n)
    else $error("interrupt asserted while disabled");
  a_cfg_readback: assert property (reg_rd && reg_addr == ADDR_CFG2 |=> reg_rdata == $past(cfg2_s))
    else $error("config read differs from written value");
endmodule
bind rxbe_top rxbe_checker i_rxbe_checker (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .signal_loss_in(signal_loss_in),
  .rx_recovered_clock(rx_recovered_clock), .rx_data_pos(rx_data_pos),
  .rx_data_neg(rx_data_neg), .signal_loss_out(signal_loss_out), .line_tx_pos(line_tx_pos),
  .line_tx_neg(line_tx_neg), .boost_gain_select(boost_gain_select),
  .decision_threshold_select(decision_threshold_select), .eq_setting(eq_setting),
  .irq_n(irq_n)
);
`default_nettype wire

// [tb/rxbe_framer_model.sv]
// Framer model counting recovered clock edges and received marks
`timescale 1ns/1ps
`default_nettype none
module rxbe_framer_model (
  input wire logic clr,
  input wire logic rx_recovered_clock,
  input wire logic rx_data_pos,
  output var int edges,
  output var int ones
);
  // sample data on each rising recovered clock edge
  always @(posedge rx_recovered_clock or posedge clr) begin
    if (clr) begin
      edges <= 0;
      ones <= 0;
    end else begin
      edges <= edges + 1;
      ones <= ones + (rx_data_pos === 1'b1 ? 1 : 0);
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the receive path back end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rxbe_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, line_clk_in = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [6:0] slice_pos = 7'h3c, slice_neg = 7'h00, line_peak = 7'h64;
  logic [7:0] tap_rx_pos = 8'h00, tap_rx_neg = 8'h00, tap_tx_pos = 8'h00, tap_tx_neg = 8'h00;
  logic signal_loss_in = 1'b0, lc_on = 1'b1, clr = 1'b0, tx_seen, neg_seen;
  logic rclk, dpos, dneg, loss, txp, txn, irq_n;
  logic [1:0] gain, thr;
  logic [4:0] eq;
  int edges, ones, bad_count = 0, check_count = 0, cyc = 0;
  logic [7:0] am [6] = '{ADDR_TAP, ADDR_JA_CFG, ADDR_CFG0, ADDR_CFG1, ADDR_CFG2, ADDR_IRQ_EN};
  logic [7:0] mk [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] tv [4] = '{8'h02, 8'h03, 8'h0a, 8'h02};
  logic [7:0] cv [4] = '{8'h42, 8'h42, 8'h42, 8'h4a};
  logic [3:0] hi = 4'b0101;
  rxbe_top i_rxbe_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slice_pos(slice_pos),
    .slice_neg(slice_neg), .line_peak(line_peak), .line_clk_in(line_clk_in),
    .tap_rx_pos(tap_rx_pos), .tap_rx_neg(tap_rx_neg), .tap_tx_pos(tap_tx_pos),
    .tap_tx_neg(tap_tx_neg), .signal_loss_in(signal_loss_in), .rx_recovered_clock(rclk),
    .rx_data_pos(dpos), .rx_data_neg(dneg), .signal_loss_out(loss), .line_tx_pos(txp),
    .line_tx_neg(txn), .boost_gain_select(gain), .decision_threshold_select(thr),
    .eq_setting(eq), .irq_n(irq_n));
  rxbe_framer_model i_rxbe_framer_model (.clr(clr), .rx_recovered_clock(rclk),
    .rx_data_pos(dpos), .edges(edges), .ones(ones));
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #200 if (lc_on) line_clk_in = ~line_clk_in;
  end
  always @(posedge clk) begin
    tx_seen <= clr ? 1'b0 : tx_seen | (txp === 1'b1);
    neg_seen <= clr ? 1'b0 : neg_seen | (dneg === 1'b1);
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("ERROR %0t run too long", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic ok(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    rd(a, d);
    ok(d === e, m);
  endtask
  task automatic meas();
    repeat (50) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (400) @(posedge clk);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    wait_n(5);
    rst_n <= 1'b1;
    wait_n(1);
    rdc(ADDR_CFG2, CFG2_RESET, "window reset value");
    rdc(ADDR_JA_CFG, JA_CFG_RESET, "depth reset value");
    rdc(8'h00, 8'h00, "unmapped read");
    ok(irq_n === 1'b1, "interrupt idle");
    for (int i = 0; i < 6; i++) begin
      wr(am[i], 8'hff);
      rdc(am[i], mk[i], "write ones");
      wr(am[i], 8'h00);
      rdc(am[i], 8'h00, "write zeros");
    end
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_CFG2, {2'h0, i[3:2], 2'h2, i[1:0]});
      wait_n(8);
      ok(gain === i[3:2] && thr === i[1:0], "gain or threshold copy");
    end
    $display("Test registers done");
    wr(ADDR_CFG0, {6'h00, MD_BYPASS});
    wr(ADDR_CFG2, 8'h08);
    wait_n(20);
    ok(dpos === 1'b1 && dneg === 1'b0 && rclk === 1'b1, "low threshold mark");
    wr(ADDR_CFG2, 8'h0b);
    wait_n(20);
    ok(dpos === 1'b0 && rclk === 1'b0, "high threshold space");
    slice_pos <= 7'h5a;
    signal_loss_in <= 1'b1;
    wr(ADDR_CFG0, 8'h12);
    meas();
    ok(edges == 0 && (rclk | dpos | dneg | loss) === 1'b0, "power down outputs");
    wr(ADDR_CFG0, {6'h00, MD_DR});
    wait_n(8);
    ok(loss === 1'b1, "loss follows after power up");
    signal_loss_in <= 1'b0;
    for (int m = 1; m < 3; m++) begin
      wr(ADDR_CFG0, 8'(m));
      meas();
      ok(edges >= 48 && edges <= 52 && ones >= 45, "recovered rate and marks");
      if (m == 1) ok(neg_seen === 1'b1, "violations on error pin");
    end
    wr(ADDR_CFG0, 8'h06);
    meas();
    ok(edges >= 48 && edges <= 52 && ones >= 45, "other clock edge");
    $display("Test line output done");
    slice_pos <= 7'h00;
    tap_rx_pos <= 8'h04;
    tap_tx_pos <= 8'h04;
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_TAP, tv[t]);
      wr(ADDR_CFG0, cv[t]);
      meas();
      ok(hi[t] ? (ones >= 45 && tx_seen) : ones == 0, "tapped data");
    end
    wr(ADDR_TAP, TAP_OFF);
    wr(ADDR_CFG0, {6'h00, MD_DR});
    slice_pos <= 7'h5a;
    $display("Test tap done");
    wr(ADDR_CFG2, 8'h00);
    wr(ADDR_CFG1, 8'h01);
    wait_n(1500);
    rd(ADDR_LINE_STAT, d);
    ok(d[4:0] === 5'd6, "loss level at high peak");
    line_peak <= 7'h20;
    wait_n(1500);
    rd(ADDR_LINE_STAT, d);
    ok(d[4:0] === 5'd23, "loss level at low peak");
    wr(ADDR_CFG1, 8'h00);
    $display("Test equalizer done");
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_JA_CFG, 8'h00);
      wr(ADDR_JA_CFG, 8'(1 + 2 * k));
      wait_n(300);
      rd(ADDR_GAP, d);
      ok(d[6:0] >= 7'((16 << k) - 4) && d[6:0] <= 7'((16 << k) + 4), "centred gap");
    end
    wr(ADDR_JA_CFG, 8'h23);
    rd(ADDR_GAP, d);
    for (int p = 0; p < 4; p++) begin
      tv[0] = d;
      wait_n(200);
      rd(ADDR_GAP, d);
      ok(d[6:0] >= tv[0][6:0], "peak hold never falls");
    end
    wr(ADDR_EVENTS, 8'h01);
    rdc(ADDR_EVENTS, 8'h00, "no slip while centred");
    wr(ADDR_JA_CFG, 8'h01);
    lc_on = 1'b0;
    wait_n(4000);
    rd(ADDR_EVENTS, d);
    ok(d[SLIP_BIT] === 1'b1 && irq_n === 1'b1, "slip flagged, masked");
    wr(ADDR_IRQ_EN, 8'h01);
    wait_n(8);
    ok(irq_n === 1'b0, "slip interrupt raised");
    lc_on = 1'b1;
    wr(ADDR_JA_CFG, 8'h00);
    wait_n(200);
    rd(ADDR_EVENTS, d);
    ok(d[SLIP_BIT] === 1'b1, "slip flag held");
    wr(ADDR_EVENTS, 8'h01);
    rd(ADDR_EVENTS, d);
    ok(d[SLIP_BIT] === 1'b0 && irq_n === 1'b1, "slip cleared");
    $display("Test jitter attenuator done");
    end_sim();
  end
endmodule
`default_nettype wire
